// ==== src/tic_interval_timer.v ====
`include "tic_defs.vh"
`default_nettype none
module tic_interval_timer #(
  parameter DIV_CYCLES = 1
) (
  input wire core_clk,
  input wire sys_rst,
  input wire xtal_tick,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_r,
  input wire interval_irq_enable,
  input wire power_down,
  output wire interval_irq,
  output wire wake_request,
  output wire [15:0] wake_vector
);
  localparam integer TICKS_PER_STEP = (`TIC_XTAL_HZ / `TIC_TICK_HZ) / DIV_CYCLES;
  localparam [31:0] PRESCALE_LAST_W = TICKS_PER_STEP - 1;
  localparam [7:0] PRESCALE_LAST = PRESCALE_LAST_W[7:0];

  reg [7:0] ctrl_r;
  reg [7:0] ctrl_nxt;
  reg [7:0] target_r;
  reg [7:0] interval_timer_r;
  reg [7:0] interval_timer_nxt;
  reg [7:0] prescale_r;
  wire [7:0] subsec_q;
  wire [7:0] sec_q;
  wire [7:0] min_q;
  wire [7:0] hour_q;
  wire subsec_wrap;
  wire sec_wrap;
  wire min_wrap;
  wire hour_wrap;

  wire time_clock_enable = ctrl_r[`TIC_BIT_TIME_CLOCK_ENABLE];
  wire interval_count_enable = ctrl_r[`TIC_BIT_INTERVAL_COUNT_ENABLE];
  wire interval_match_flag = ctrl_r[`TIC_BIT_FLAG];
  wire single_interval_mode = ctrl_r[`TIC_BIT_SINGLE];
  wire [1:0] timebase_sel = {ctrl_r[`TIC_BIT_TS_HI], ctrl_r[`TIC_BIT_TS_LO]};

  function wr_hit;
    input [7:0] addr;
    input [7:0] reg_addr;
    input wr;
    begin
      wr_hit = wr && (addr == reg_addr);
    end
  endfunction

  // Crystal 1/128 s step, every (32768/128)/DIV_CYCLES xtal_tick pulses, so the count depends on DIV_CYCLES
  wire step = time_clock_enable && xtal_tick && (prescale_r == PRESCALE_LAST);
  always @(posedge core_clk) begin
    if (sys_rst || !time_clock_enable) begin
      prescale_r <= 8'h00;
    end else if (xtal_tick) begin
      prescale_r <= step ? 8'h00 : prescale_r + 8'h01;
    end
  end

  // Time registers, cleared while clock disabled, writable for preload only while clock enabled
  wire time_clear = !time_clock_enable;
  tic_wrap_counter #(.MAX(`TIC_SUBSEC_MAX)) u_subsec (
    .core_clk(core_clk), .sys_rst(sys_rst), .clear(time_clear),
    .load(wr_hit(sfr_addr, `TIC_ADDR_SUBSEC, sfr_wr)), .load_data(sfr_wdata),
    .inc(step), .count_r(subsec_q), .wrap(subsec_wrap));
  tic_wrap_counter #(.MAX(`TIC_SEC_MAX)) u_sec (
    .core_clk(core_clk), .sys_rst(sys_rst), .clear(time_clear),
    .load(wr_hit(sfr_addr, `TIC_ADDR_SEC, sfr_wr)), .load_data(sfr_wdata),
    .inc(subsec_wrap), .count_r(sec_q), .wrap(sec_wrap));
  tic_wrap_counter #(.MAX(`TIC_MIN_MAX)) u_min (
    .core_clk(core_clk), .sys_rst(sys_rst), .clear(time_clear),
    .load(wr_hit(sfr_addr, `TIC_ADDR_MIN, sfr_wr)), .load_data(sfr_wdata),
    .inc(sec_wrap), .count_r(min_q), .wrap(min_wrap));
  tic_wrap_counter #(.MAX(`TIC_HOUR_MAX)) u_hour (
    .core_clk(core_clk), .sys_rst(sys_rst), .clear(time_clear),
    .load(wr_hit(sfr_addr, `TIC_ADDR_HOUR, sfr_wr)), .load_data(sfr_wdata),
    .inc(min_wrap), .count_r(hour_q), .wrap(hour_wrap));

  // Timebase overflow selection
  reg base_tick;
  always @* begin
    case (timebase_sel)
      `TIC_TS_SUBSEC: base_tick = step;
      `TIC_TS_SEC: base_tick = subsec_wrap;
      `TIC_TS_MIN: base_tick = sec_wrap;
      `TIC_TS_HOUR: base_tick = min_wrap;
      default: base_tick = 1'b0;
    endcase
  end

  // Interval counter and match
  wire interval_step = interval_count_enable && base_tick;
  wire [7:0] interval_inc = interval_timer_r + 8'h01;
  wire match = interval_step && (interval_inc == target_r);
  always @* begin
    interval_timer_nxt = interval_timer_r;
    if (!interval_count_enable) begin
      interval_timer_nxt = 8'h00;
    end else if (match) begin
      interval_timer_nxt = 8'h00;
    end else if (interval_step) begin
      interval_timer_nxt = interval_inc;
    end
  end

  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_hit(sfr_addr, `TIC_ADDR_CTRL, sfr_wr)) begin
      ctrl_nxt = sfr_wdata & `TIC_CTRL_WMASK;
      // Flag only clears by writing zero, never set by software
      ctrl_nxt[`TIC_BIT_FLAG] = interval_match_flag & sfr_wdata[`TIC_BIT_FLAG];
    end
    if (match) begin
      ctrl_nxt[`TIC_BIT_FLAG] = 1'b1;
      if (single_interval_mode) begin
        ctrl_nxt[`TIC_BIT_INTERVAL_COUNT_ENABLE] = 1'b0;
      end
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_r <= `TIC_CTRL_RESET;
      target_r <= 8'h00;
      interval_timer_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      interval_timer_r <= interval_timer_nxt;
      if (wr_hit(sfr_addr, `TIC_ADDR_TARGET, sfr_wr)) begin
        target_r <= sfr_wdata;
      end
    end
  end

  // Register read port
  always @(posedge core_clk) begin
    if (sys_rst) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `TIC_ADDR_CTRL: sfr_rdata_r <= ctrl_r;
        `TIC_ADDR_SUBSEC: sfr_rdata_r <= subsec_q;
        `TIC_ADDR_SEC: sfr_rdata_r <= sec_q;
        `TIC_ADDR_MIN: sfr_rdata_r <= min_q;
        `TIC_ADDR_HOUR: sfr_rdata_r <= hour_q;
        `TIC_ADDR_TARGET: sfr_rdata_r <= target_r;
        default: sfr_rdata_r <= 8'h00;
      endcase
    end
  end

  assign interval_irq = interval_match_flag && interval_irq_enable;
  assign wake_request = interval_irq && power_down;
  assign wake_vector = `TIC_VECTOR;
endmodule // tic_interval_timer
`default_nettype wire

// ==== src/tic_defs.vh ====
`ifndef TIC_DEFS_VH
`define TIC_DEFS_VH
`define TIC_ADDR_CTRL 8'hA1
`define TIC_ADDR_SUBSEC 8'hA2
`define TIC_ADDR_SEC 8'hA3
`define TIC_ADDR_MIN 8'hA4
`define TIC_ADDR_HOUR 8'hA5
`define TIC_ADDR_TARGET 8'hA6
`define TIC_CTRL_RESET 8'h00
`define TIC_BIT_TIME_CLOCK_ENABLE 0
`define TIC_BIT_INTERVAL_COUNT_ENABLE 1
`define TIC_BIT_FLAG 2
`define TIC_BIT_SINGLE 3
`define TIC_BIT_TS_LO 4
`define TIC_BIT_TS_HI 5
`define TIC_CTRL_WMASK 8'h7F
`define TIC_SUBSEC_MAX 8'h7F
`define TIC_SEC_MAX 8'h3B
`define TIC_MIN_MAX 8'h3B
`define TIC_HOUR_MAX 8'h17
`define TIC_TS_SUBSEC 2'h0
`define TIC_TS_SEC 2'h1
`define TIC_TS_MIN 2'h2
`define TIC_TS_HOUR 2'h3
`define TIC_VECTOR 16'h0053
`define TIC_XTAL_HZ 32768
`define TIC_TICK_HZ 128
`endif

// ==== src/tic_wrap_counter.v ====
`default_nettype none
module tic_wrap_counter #(
  parameter [7:0] MAX = 8'h3B
) (
  input wire core_clk,
  input wire sys_rst,
  input wire clear,
  input wire load,
  input wire [7:0] load_data,
  input wire inc,
  output reg [7:0] count_r,
  output wire wrap
);
  reg [7:0] count_nxt;
  assign wrap = inc && (count_r == MAX);
  always @* begin
    count_nxt = count_r;
    if (clear) begin
      count_nxt = 8'h00;
    end else if (load) begin
      count_nxt = load_data;
    end else if (inc) begin
      count_nxt = wrap ? 8'h00 : count_r + 8'h01;
    end
  end
  always @(posedge core_clk) begin
    if (sys_rst) begin
      count_r <= 8'h00;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule // tic_wrap_counter
`default_nettype wire

// ==== tb/tic_interval_timer_sva.sv ====
`default_nettype none
module tic_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata_r,
  input wire logic interval_irq_enable,
  input wire logic power_down,
  input wire logic interval_irq,
  input wire logic wake_request,
  input wire logic [15:0] wake_vector
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_vector_fixed: assert property (wake_vector == 16'h0053) else $error("bad vector");
  a_wake_cause: assert property (wake_request == (interval_irq && power_down)) else $error("bad wake");
  a_irq_gated: assert property (interval_irq |-> interval_irq_enable) else $error("irq ungated");
  a_flag_sticky: assert property (interval_irq && !(sfr_wr && sfr_addr == 8'hA1 && !sfr_wdata[2])
    |=> interval_irq || !interval_irq_enable) else $error("flag lost");
  a_ctrl_top_zero: assert property (sfr_rd && sfr_addr == 8'hA1 |=> !sfr_rdata_r[7]) else $error("bit7");
  a_unmapped_zero: assert property (sfr_rd && sfr_addr == 8'hA7 |=> sfr_rdata_r == 8'h00) else $error("unmapped");
  a_hour_range: assert property (sfr_rd && sfr_addr == 8'hA5 |=> sfr_rdata_r <= 8'h17) else $error("hour");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata_r)) else $error("rdata moved");
endmodule // tic_chk
`default_nettype wire

// ==== tb/tb_time_interval_counter.sv ====
`include "tic_defs.vh"
`default_nettype none
module tb_time_interval_counter;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, sys_rst = 1, xtal_tick = 0, sfr_wr = 0, sfr_rd = 0;
  logic interval_irq_enable = 1, power_down = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata_r;
  logic interval_irq, wake_request;
  logic [15:0] wake_vector;
  int n_mismatch = 0, cmp_count = 0;
  logic [7:0] mx [4] = '{`TIC_SUBSEC_MAX, `TIC_SEC_MAX, `TIC_MIN_MAX, `TIC_HOUR_MAX};
  tic_interval_timer #(.DIV_CYCLES(128)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .xtal_tick(xtal_tick),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
    .interval_irq_enable(interval_irq_enable), .power_down(power_down), .interval_irq(interval_irq),
    .wake_request(wake_request), .wake_vector(wake_vector));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  always @(negedge core_clk) xtal_tick <= ~xtal_tick;
  task automatic final_report;
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(negedge core_clk);
    sfr_wr = 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    {sfr_rd, sfr_addr} = {1'b1, a};
    @(negedge core_clk);
    sfr_rd = 0;
    check(sfr_rdata_r, exp);
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 60 && interval_irq !== 1'b1; i++) @(negedge core_clk);
  endtask
  initial begin
    logic [7:0] t;
    void'($urandom(32'h3fd0));
    repeat (5) @(negedge core_clk);
    sys_rst = 0;
    for (int a = 8'hA1; a <= 8'hA7; a++) rdc(8'(a), 8'h00);
    t = $urandom;
    wr(`TIC_ADDR_TARGET, t);
    rdc(`TIC_ADDR_TARGET, t);
    wr(`TIC_ADDR_CTRL, 8'hFE);
    rdc(`TIC_ADDR_CTRL, 8'h7A);
    wr(`TIC_ADDR_CTRL, 8'h01);
    wr(`TIC_ADDR_SEC, 8'h2A);
    rdc(`TIC_ADDR_SEC, 8'h2A);
    wr(`TIC_ADDR_CTRL, 8'h00);
    rdc(`TIC_ADDR_SEC, 8'h00);
    for (int ts = 0; ts < 4; ts++) begin
      wr(`TIC_ADDR_TARGET, 8'h01);
      wr(`TIC_ADDR_CTRL, 8'(ts * 16 + 3));
      for (int r = ts; r >= 0; r--) wr(8'(8'hA2 + r), mx[r]);
      wait_irq();
      check(interval_irq, 1'b1);
      rdc(`TIC_ADDR_CTRL, 8'(ts * 16 + 7));
      if (ts == 3) rdc(`TIC_ADDR_HOUR, 8'h00);
      power_down = 1;
      @(negedge core_clk);
      check(wake_request, 1'b1);
      power_down = 0;
      wr(`TIC_ADDR_CTRL, 8'h04);
      check(interval_irq, 1'b1);
      wr(`TIC_ADDR_CTRL, 8'h00);
      check(interval_irq, 1'b0);
    end
    wr(`TIC_ADDR_TARGET, 8'h03);
    wr(`TIC_ADDR_CTRL, 8'h0B);
    wait_irq();
    check(interval_irq, 1'b1);
    rdc(`TIC_ADDR_CTRL, 8'h0D);
    interval_irq_enable = 0;
    @(negedge core_clk);
    check(interval_irq, 1'b0);
    interval_irq_enable = 1;
    @(negedge core_clk);
    check(interval_irq, 1'b1);
    final_report();
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule // tb_time_interval_counter
bind tic_interval_timer tic_chk i_chk (.core_clk(core_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .interval_irq_enable(interval_irq_enable),
  .power_down(power_down), .interval_irq(interval_irq), .wake_request(wake_request), .wake_vector(wake_vector));
`default_nettype wire
